// ### src/alm_pkg.sv
// package for the layer-4 acl rule byte store
// assumes a wishbone classic slave with 32-bit data and byte-addressed registers
package alm_pkg;
	// wishbone register byte addresses
	localparam logic [7:0] ALM_ADR_CTRL = 8'h6E;
	localparam logic [7:0] ALM_ADR_OFFSET = 8'h6F;
	localparam logic [7:0] ALM_ADR_DATA = 8'hA0;
	localparam logic [7:0] ALM_ADR_MATCH = 8'hB0;
	// indirect control fields
	localparam int ALM_TSEL_HI = 7;
	localparam int ALM_TSEL_LO = 5;
	localparam logic [2:0] ALM_TSEL_ACL = 3'h2;
	localparam logic [3:0] ALM_PORT_FIRST = 4'h1;
	localparam logic [3:0] ALM_PORT_LAST = 4'h4;
	// rule byte offsets
	localparam logic [7:0] ALM_OFS_MIN_LOW = 8'h05;
	localparam logic [7:0] ALM_OFS_CMP_PROT = 8'h06;
	localparam logic [7:0] ALM_OFS_PROT_FLAG = 8'h07;
	localparam logic [7:0] ALM_OFS_FLAG_MASK = 8'h08;
	localparam logic [7:0] ALM_OFS_FLAG_VAL = 8'h09;
	localparam logic [7:0] ALM_OFS_ACTION = 8'h0A;
	// reset values
	localparam logic [7:0] ALM_RST_BYTE = 8'h00;
	localparam logic [7:0] ALM_RST_CTRL = 8'h00;
	// port compare modes
	typedef enum logic [1:0] {
		ALM_CMP_OFF = 2'b00,
		ALM_CMP_EQ = 2'b01,
		ALM_CMP_IN = 2'b10,
		ALM_CMP_OUT = 2'b11
	} alm_cmp_type;
	// bus access fsm
	typedef enum logic [1:0] {
		ALM_BUS_IDLE = 2'b00,
		ALM_BUS_ACK = 2'b01
	} alm_bus_type;
endpackage : alm_pkg

// ### src/alm_rule_if.sv
// interface carrying one port's rule bytes to the flag matcher
// assumes one clock; fields are plain levels
`timescale 1ns/1ps
interface alm_rule_if;
	logic flag_match_enable;
	logic [7:0] tcp_flag_mask;
	logic [7:0] acl_tcp_flag_value;
	logic [7:0] seg_flags;
	logic flag_hit;
	modport store (output flag_match_enable, output tcp_flag_mask, output acl_tcp_flag_value,
		output seg_flags, input flag_hit);
	modport match (input flag_match_enable, input tcp_flag_mask, input acl_tcp_flag_value,
		input seg_flags, output flag_hit);
endinterface : alm_rule_if

// ### src/alm_flag_match.sv
// tcp flag matcher for one rule entry
// assumes all inputs are on clk_i; result is combinational, registered by the caller
`timescale 1ns/1ps
module alm_flag_match (
	alm_rule_if.match rule
);
	import alm_pkg::*;
	// disabled matching passes every segment
	assign rule.flag_hit = !rule.flag_match_enable ||
		((rule.seg_flags & rule.tcp_flag_mask) == (rule.acl_tcp_flag_value & rule.tcp_flag_mask)); // [R11]
endmodule : alm_flag_match

// ### src/alm_store.sv
// layer-4 acl rule byte store for four switch ports with indirect wishbone access
// assumes wishbone classic master on clk_i, synchronous active-high reset
//
// Function
// [R1] control register bits 7:5 = 010 pick acl table, bits 3:0 pick port 1-4
// [R2] offset register picks a rule byte, read or written through data register 0xA0
// [R3] minimum port low byte is 8-bit read/write, reset zero
// [R4] compare mode bits 2:1 of byte 0x06: off, equal either, inside, outside
// [R5] protocol bit 7 in byte 0x06 bit 0, bits 6:0 in byte 0x07 bits 7:1
// [R6] byte 0x07 bit 0 enables tcp flag matching, reset zero
// [R7] byte 0x08 holds 8-bit tcp flag mask, reset zero
// [R8] byte 0x09 holds 8-bit tcp flag value, reset zero
// [R9] software keeps layer 2, 3 and 4 criteria in separate entries
// [R10] offset 0x0A starts the action part, reached through the same data register
// [R11] flags match when flags and mask equal stored value and mask
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module alm_store #(
	parameter int NPORTS = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// segment under test
	input wire logic [15:0] seg_port_i,
	input wire logic [7:0] seg_protocol_i,
	input wire logic [7:0] seg_flags_i,
	input wire logic [3:0] seg_src_port_i,
	// match results
	output logic flag_hit_o,
	output logic l4_hit_o
);
	import alm_pkg::*;

	// the port index is two bits wide, so only four ports can be served
	if (NPORTS != 4) begin : g_bad_nports
		$error("alm_store serves exactly four ports");
	end

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] ofs;
		logic [NPORTS-1:0][7:0] min_low;
		logic [NPORTS-1:0][1:0] port_compare_mode;
		logic [NPORTS-1:0][7:0] ip_protocol_value;
		logic [NPORTS-1:0] flag_match_enable;
		logic [NPORTS-1:0][7:0] tcp_flag_mask;
		logic [NPORTS-1:0][7:0] acl_tcp_flag_value;
		logic [NPORTS-1:0][7:0] action0;
		alm_bus_type bus;
		logic [31:0] dat;
		logic ack;
		logic flag_hit;
		logic l4_hit;
	} alm_state_type;

	alm_state_type s_q;
	alm_state_type s_d;

	// max port bytes live outside this block; a parameter stands in for the upper bound
	localparam logic [15:0] MAX_PORT = 16'hFFFF;

	alm_rule_if rif ();
	alm_flag_match u_match (
		.rule(rif.match)
	);

	logic sel_ok;
	logic [1:0] pidx;
	logic [1:0] sidx;
	logic [7:0] rd_byte;
	logic [15:0] min_port;
	logic port_ok;
	logic proto_ok;
	logic seg_ok;

	// table select must be acl and port must be 1..4
	assign sel_ok = (s_q.ctrl[ALM_TSEL_HI:ALM_TSEL_LO] == ALM_TSEL_ACL) &&
		(s_q.ctrl[3:0] >= ALM_PORT_FIRST) && (s_q.ctrl[3:0] <= ALM_PORT_LAST); // [R1]
	assign pidx = 2'(s_q.ctrl[3:0] - ALM_PORT_FIRST);
	assign sidx = 2'(seg_src_port_i - ALM_PORT_FIRST);
	assign seg_ok = (seg_src_port_i >= ALM_PORT_FIRST) && (seg_src_port_i <= ALM_PORT_LAST);

	assign rif.flag_match_enable = s_q.flag_match_enable[sidx];
	assign rif.tcp_flag_mask = s_q.tcp_flag_mask[sidx];
	assign rif.acl_tcp_flag_value = s_q.acl_tcp_flag_value[sidx];
	assign rif.seg_flags = seg_flags_i;

	// read path of the indirect byte
	always_comb begin
		rd_byte = 8'h00;
		if (sel_ok) begin
			case (s_q.ofs)
				ALM_OFS_MIN_LOW: rd_byte = s_q.min_low[pidx]; // [R3]
				ALM_OFS_CMP_PROT: rd_byte = {5'h0, s_q.port_compare_mode[pidx],
					s_q.ip_protocol_value[pidx][7]}; // [R4] [R5]
				ALM_OFS_PROT_FLAG: rd_byte = {s_q.ip_protocol_value[pidx][6:0],
					s_q.flag_match_enable[pidx]}; // [R5] [R6]
				ALM_OFS_FLAG_MASK: rd_byte = s_q.tcp_flag_mask[pidx]; // [R7]
				ALM_OFS_FLAG_VAL: rd_byte = s_q.acl_tcp_flag_value[pidx]; // [R8]
				ALM_OFS_ACTION: rd_byte = s_q.action0[pidx]; // [R10]
				default: rd_byte = 8'h00;
			endcase
		end
	end

	// port range compare; low byte is held here, high byte fixed at zero in this block
	assign min_port = {8'h00, s_q.min_low[sidx]};
	always_comb begin
		case (alm_cmp_type'(s_q.port_compare_mode[sidx]))
			ALM_CMP_OFF: port_ok = 1'b1;
			ALM_CMP_EQ: port_ok = (seg_port_i == min_port) || (seg_port_i == MAX_PORT); // [R4]
			ALM_CMP_IN: port_ok = (seg_port_i >= min_port) && (seg_port_i <= MAX_PORT); // [R4]
			ALM_CMP_OUT: port_ok = (seg_port_i < min_port) || (seg_port_i > MAX_PORT); // [R4]
			default: port_ok = 1'b1;
		endcase
	end
	assign proto_ok = (seg_protocol_i == s_q.ip_protocol_value[sidx]);

	always_comb begin
		s_d = s_q;
		s_d.flag_hit = seg_ok && rif.flag_hit;
		s_d.l4_hit = seg_ok && rif.flag_hit && port_ok && proto_ok;
		case (s_q.bus)
			ALM_BUS_IDLE: begin
				s_d.ack = 1'b0;
				if (cyc_i && stb_i) begin
					s_d.ack = 1'b1;
					s_d.bus = ALM_BUS_ACK;
					s_d.dat = 32'h0000_0000;
					if (we_i && sel_i[0]) begin
						case (adr_i)
							ALM_ADR_CTRL: s_d.ctrl = dat_i[7:0]; // [R1]
							ALM_ADR_OFFSET: s_d.ofs = dat_i[7:0]; // [R2]
							ALM_ADR_DATA: begin
								if (sel_ok) begin
									case (s_q.ofs)
										ALM_OFS_MIN_LOW: s_d.min_low[pidx] = dat_i[7:0]; // [R3]
										ALM_OFS_CMP_PROT: begin
											s_d.port_compare_mode[pidx] = dat_i[2:1]; // [R4]
											s_d.ip_protocol_value[pidx][7] = dat_i[0]; // [R5]
										end
										ALM_OFS_PROT_FLAG: begin
											s_d.ip_protocol_value[pidx][6:0] = dat_i[7:1]; // [R5]
											s_d.flag_match_enable[pidx] = dat_i[0]; // [R6]
										end
										ALM_OFS_FLAG_MASK: s_d.tcp_flag_mask[pidx] = dat_i[7:0]; // [R7]
										ALM_OFS_FLAG_VAL: s_d.acl_tcp_flag_value[pidx] = dat_i[7:0]; // [R8]
										ALM_OFS_ACTION: s_d.action0[pidx] = dat_i[7:0]; // [R10]
										default: s_d.ofs = s_q.ofs;
									endcase
								end
							end
							default: s_d.ofs = s_q.ofs;
						endcase
					end else if (!we_i) begin
						case (adr_i)
							ALM_ADR_CTRL: s_d.dat = {24'h000000, s_q.ctrl};
							ALM_ADR_OFFSET: s_d.dat = {24'h000000, s_q.ofs};
							ALM_ADR_DATA: s_d.dat = {24'h000000, rd_byte}; // [R2]
							ALM_ADR_MATCH: s_d.dat = {30'h0, s_q.l4_hit, s_q.flag_hit};
							default: s_d.dat = 32'h0000_0000;
						endcase
					end
				end
			end
			ALM_BUS_ACK: begin
				s_d.ack = 1'b0;
				s_d.bus = ALM_BUS_IDLE;
			end
			default: begin
				s_d.ack = 1'b0;
				s_d.bus = ALM_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.ctrl <= ALM_RST_CTRL;
			s_q.ofs <= ALM_RST_BYTE;
			s_q.bus <= ALM_BUS_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign dat_o = s_q.dat;
	assign ack_o = s_q.ack;
	assign flag_hit_o = s_q.flag_hit;
	assign l4_hit_o = s_q.l4_hit;

	// assertions
	sequence seq_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence seq_ack_drop;
		ack_o ##1 !ack_o;
	endsequence

	chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		seq_req |=> seq_ack_drop)
		else $error("ack not a single cycle after request");
	chk_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		(seq_req and (we_i && sel_i[0] && adr_i == ALM_ADR_CTRL)) |=> s_q.ctrl == $past(dat_i[7:0]))
		else $error("control register not written");
	chk_data_read: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		(seq_req and (!we_i && adr_i == ALM_ADR_DATA)) |=> dat_o[7:0] == $past(rd_byte) && dat_o[31:8] == 24'h000000)
		else $error("indirect read data wrong");
	chk_min_low_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
		(seq_req and (we_i && sel_i[0] && adr_i == ALM_ADR_DATA && sel_ok && s_q.ofs == ALM_OFS_MIN_LOW))
		|=> s_q.min_low[$past(pidx)] == $past(dat_i[7:0]))
		else $error("minimum port low byte not stored");
	chk_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		(sel_ok && s_q.ofs == ALM_OFS_CMP_PROT) |-> rd_byte[7:3] == 5'h0)
		else $error("reserved bits of byte 0x06 not zero");
	chk_proto_split: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
		(sel_ok && s_q.ofs == ALM_OFS_PROT_FLAG) |-> rd_byte[7:1] == s_q.ip_protocol_value[pidx][6:0])
		else $error("protocol low bits misplaced");
	chk_enable_pos: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
		(sel_ok && s_q.ofs == ALM_OFS_PROT_FLAG) |-> rd_byte[0] == s_q.flag_match_enable[pidx])
		else $error("flag match enable misplaced");
	chk_mask_read: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
		(sel_ok && s_q.ofs == ALM_OFS_FLAG_MASK) |-> rd_byte == s_q.tcp_flag_mask[pidx])
		else $error("flag mask read wrong");
	chk_value_read: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
		(sel_ok && s_q.ofs == ALM_OFS_FLAG_VAL) |-> rd_byte == s_q.acl_tcp_flag_value[pidx])
		else $error("flag value read wrong");
	chk_action_read: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
		(sel_ok && s_q.ofs == ALM_OFS_ACTION) |-> rd_byte == s_q.action0[pidx])
		else $error("action byte read wrong");
	chk_flag_match: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		(seg_ok && s_q.flag_match_enable[sidx] &&
		((seg_flags_i & s_q.tcp_flag_mask[sidx]) != (s_q.acl_tcp_flag_value[sidx] & s_q.tcp_flag_mask[sidx])))
		|=> !flag_hit_o)
		else $error("flag mismatch reported as hit");

	// accepted indirect data writes, one property per rule byte
	sequence seq_data_wr;
		cyc_i && stb_i && !ack_o && we_i && sel_i[0] && adr_i == ALM_ADR_DATA && sel_ok;
	endsequence

	chk_mode_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R4] [R5]
		(seq_data_wr and (s_q.ofs == ALM_OFS_CMP_PROT))
		|=> s_q.port_compare_mode[$past(pidx)] == $past(dat_i[2:1]) &&
		s_q.ip_protocol_value[$past(pidx)][7] == $past(dat_i[0]))
		else $error("compare mode or protocol bit 7 not stored");
	chk_proto_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R5] [R6]
		(seq_data_wr and (s_q.ofs == ALM_OFS_PROT_FLAG))
		|=> s_q.ip_protocol_value[$past(pidx)][6:0] == $past(dat_i[7:1]) &&
		s_q.flag_match_enable[$past(pidx)] == $past(dat_i[0]))
		else $error("protocol low bits or flag enable not stored");
	chk_mask_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
		(seq_data_wr and (s_q.ofs == ALM_OFS_FLAG_MASK))
		|=> s_q.tcp_flag_mask[$past(pidx)] == $past(dat_i[7:0]))
		else $error("flag mask not stored");
	chk_value_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
		(seq_data_wr and (s_q.ofs == ALM_OFS_FLAG_VAL))
		|=> s_q.acl_tcp_flag_value[$past(pidx)] == $past(dat_i[7:0]))
		else $error("flag value not stored");
	chk_action_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
		(seq_data_wr and (s_q.ofs == ALM_OFS_ACTION))
		|=> s_q.action0[$past(pidx)] == $past(dat_i[7:0]))
		else $error("action byte not stored");
	chk_offset_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		(seq_req and (we_i && sel_i[0] && adr_i == ALM_ADR_OFFSET))
		|=> s_q.ofs == $past(dat_i[7:0]))
		else $error("offset register not written");

	// refused accesses leave every rule byte alone
	chk_refused_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		(seq_req and (we_i && adr_i == ALM_ADR_DATA && !sel_ok))
		|=> $stable(s_q.min_low) && $stable(s_q.tcp_flag_mask) && $stable(s_q.acl_tcp_flag_value) &&
		$stable(s_q.action0) && $stable(s_q.port_compare_mode) && $stable(s_q.ip_protocol_value))
		else $error("write outside the acl table changed a rule byte");
	chk_sel_ignored: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		(seq_req and (we_i && !sel_i[0]))
		|=> $stable(s_q.ctrl) && $stable(s_q.ofs) && $stable(s_q.min_low) && $stable(s_q.tcp_flag_mask))
		else $error("write with low byte lane off took effect");
	chk_refused_read: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		(seq_req and (!we_i && adr_i == ALM_ADR_DATA && !sel_ok))
		|=> dat_o == 32'h0000_0000)
		else $error("read outside the acl table not zero");
	chk_no_table: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		!sel_ok |-> rd_byte == 8'h00)
		else $error("indirect byte visible without acl table selected");
	chk_reset_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [R3] [R6] [R7] [R8]
		$past(rst_i) |-> s_q.min_low == '0 && s_q.port_compare_mode == '0 && s_q.ip_protocol_value == '0 &&
		s_q.flag_match_enable == '0 && s_q.tcp_flag_mask == '0 && s_q.acl_tcp_flag_value == '0 &&
		!ack_o && dat_o == 32'h0000_0000)
		else $error("rule bytes or bus outputs not cleared by reset");

	// bus handshake and read data
	chk_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		ack_o |-> $past(cyc_i && stb_i && !ack_o))
		else $error("ack without a request");
	chk_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		((!cyc_i || !stb_i) && !ack_o) |=> !ack_o)
		else $error("ack while bus idle");
	chk_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		ack_o |-> dat_o[31:8] == 24'h000000)
		else $error("upper read data bits not zero");
	chk_ctrl_read: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		(seq_req and (!we_i && adr_i == ALM_ADR_CTRL))
		|=> dat_o == {24'h000000, $past(s_q.ctrl)})
		else $error("control register read wrong");
	chk_match_read: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		(seq_req and (!we_i && adr_i == ALM_ADR_MATCH))
		|=> dat_o == {30'h0, $past(l4_hit_o), $past(flag_hit_o)})
		else $error("match status read wrong");
	chk_min_read: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
		(sel_ok && s_q.ofs == ALM_OFS_MIN_LOW) |-> rd_byte == s_q.min_low[pidx])
		else $error("minimum port low byte read wrong");
	chk_mode_read: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		(sel_ok && s_q.ofs == ALM_OFS_CMP_PROT)
		|-> rd_byte[2:1] == s_q.port_compare_mode[pidx] && rd_byte[0] == s_q.ip_protocol_value[pidx][7])
		else $error("compare mode read wrong");

	// match results
	chk_flag_pass: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		(seg_ok && (!s_q.flag_match_enable[sidx] ||
		((seg_flags_i & s_q.tcp_flag_mask[sidx]) == (s_q.acl_tcp_flag_value[sidx] & s_q.tcp_flag_mask[sidx]))))
		|=> flag_hit_o)
		else $error("flag match not reported");
	chk_seg_range: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		!seg_ok |=> !flag_hit_o && !l4_hit_o)
		else $error("hit reported for a source port outside 1 to 4");
	chk_proto_miss: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
		(seg_ok && seg_protocol_i != s_q.ip_protocol_value[sidx]) |=> !l4_hit_o)
		else $error("layer-4 hit with wrong protocol");
	chk_mode_off: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		(seg_ok && s_q.port_compare_mode[sidx] == ALM_CMP_OFF && seg_protocol_i == s_q.ip_protocol_value[sidx])
		|=> l4_hit_o == flag_hit_o)
		else $error("disabled port compare still filters");
	chk_mode_equal: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		(seg_ok && s_q.port_compare_mode[sidx] == ALM_CMP_EQ && seg_port_i != {8'h00, s_q.min_low[sidx]} &&
		seg_port_i != MAX_PORT) |=> !l4_hit_o)
		else $error("equal mode hit on a port matching neither bound");
	chk_mode_inside: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		(seg_ok && s_q.port_compare_mode[sidx] == ALM_CMP_IN && seg_port_i < {8'h00, s_q.min_low[sidx]})
		|=> !l4_hit_o)
		else $error("inside mode hit below the minimum");
	chk_mode_outside: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		(seg_ok && s_q.port_compare_mode[sidx] == ALM_CMP_OUT && seg_port_i >= {8'h00, s_q.min_low[sidx]})
		|=> !l4_hit_o)
		else $error("outside mode hit inside the range");
endmodule : alm_store

// ### testbench/alm_store_test.sv
// self-checking bench for the layer-4 acl rule byte store
// assumes alm_pkg and alm_store are compiled first; the bench drives every port itself
`timescale 1ns/1ps
module alm_store_test;
	import alm_pkg::*;
	typedef struct {string nm; logic [31:0] v;} alm_exp_type;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 32'h00000000;
	logic [15:0] seg_port_i = 16'h0000;
	logic [7:0] seg_protocol_i = 8'h00;
	logic [7:0] seg_flags_i = 8'h00;
	logic [3:0] seg_src_port_i = 4'h1;
	logic [31:0] dat_o;
	logic ack_o;
	logic flag_hit_o;
	logic l4_hit_o;
	int num_errors = 0;
	int checks = 0;
	int cycles = 0;
	alm_exp_type exp_q[$];
	logic [7:0] img [1:4][5:10];
	alm_store dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .seg_port_i(seg_port_i),
		.seg_protocol_i(seg_protocol_i), .seg_flags_i(seg_flags_i), .seg_src_port_i(seg_src_port_i),
		.flag_hit_o(flag_hit_o), .l4_hit_o(l4_hit_o));
	always #50 clk_i = ~clk_i;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, want, seen);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize
	// one classic cycle; held until ack is sampled, then released for at least one idle edge
	// a stuck slave is ended by the cycle ceiling, not here
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= {24'h000000, d};
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] want, input string nm);
		exp_q.push_back('{nm, want});
		bus(1'b0, a, 8'h00);
	endtask : rd
	task automatic pick(input logic [3:0] p, input logic [7:0] o);
		bus(1'b1, ALM_ADR_CTRL, {ALM_TSEL_ACL, 1'b0, p});
		bus(1'b1, ALM_ADR_OFFSET, o);
	endtask : pick
	task automatic wbyte(input logic [3:0] p, input logic [7:0] o, input logic [7:0] d);
		pick(p, o);
		bus(1'b1, ALM_ADR_DATA, d);
		// reserved upper bits of byte 06 are read-only zero
		img[p][o] = (o == ALM_OFS_CMP_PROT) ? (d & 8'h07) : d;
	endtask : wbyte
	task automatic rbyte(input logic [3:0] p, input logic [7:0] o);
		pick(p, o);
		rd(ALM_ADR_DATA, {24'h000000, img[p][o]}, "rule byte");
	endtask : rbyte
	// results are judged where they appear: every read ack takes the oldest note
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 20000) begin
			num_errors++;
			summarize();
		end
		if (ack_o === 1'b1 && we_i === 1'b0) begin
			if (exp_q.size() == 0) begin
				chk("unexpected ack", 32'h1, 32'h0);
			end else begin
				chk(exp_q[0].nm, dat_o, exp_q[0].v);
				void'(exp_q.pop_front());
			end
		end
	end
	initial begin
		logic [7:0] d, mk, fv, mn, pr, fl;
		logic [1:0] m;
		logic fen, fok, pok;
		logic [15:0] sp;
		void'($urandom(32'h1e7a9089));
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int p = 1; p <= 4; p++) begin
			for (int o = 5; o <= 10; o++) begin
				img[p][o] = ALM_RST_BYTE;
				rbyte(p[3:0], o[7:0]);
			end
		end
		for (int p = 1; p <= 4; p++) begin
			for (int o = 5; o <= 10; o++) begin
				d = 8'($urandom);
				wbyte(p[3:0], o[7:0], d);
			end
		end
		for (int p = 4; p >= 1; p--) begin
			for (int o = 5; o <= 10; o++) begin
				rbyte(p[3:0], o[7:0]);
			end
		end
		bus(1'b1, ALM_ADR_CTRL, {3'h1, 5'h1});
		rd(ALM_ADR_DATA, 32'h0, "other table");
		bus(1'b1, ALM_ADR_CTRL, {ALM_TSEL_ACL, 5'h5});
		rd(ALM_ADR_DATA, 32'h0, "port five");
		pick(4'h2, 8'h0B);
		rd(ALM_ADR_DATA, 32'h0, "offset 0B");
		rd(8'h10, 32'h0, "unmapped");
		// refused writes: another table, then the low byte lane switched off
		pick(4'h1, ALM_OFS_ACTION);
		bus(1'b1, ALM_ADR_CTRL, {3'h1, 5'h1});
		bus(1'b1, ALM_ADR_DATA, ~img[1][10]);
		rbyte(4'h1, ALM_OFS_ACTION);
		pick(4'h1, ALM_OFS_MIN_LOW);
		bus(1'b1, ALM_ADR_DATA, ~img[1][5], 4'hE);
		rbyte(4'h1, ALM_OFS_MIN_LOW);
		for (int i = 0; i < 40; i++) begin
			mk = 8'($urandom);
			fv = 8'($urandom);
			mn = 8'($urandom);
			pr = 8'($urandom);
			m = 2'(i);
			fen = 1'($urandom);
			wbyte(4'(i % 4 + 1), ALM_OFS_MIN_LOW, mn);
			wbyte(4'(i % 4 + 1), ALM_OFS_CMP_PROT, {5'h0, m, pr[7]});
			wbyte(4'(i % 4 + 1), ALM_OFS_PROT_FLAG, {pr[6:0], fen});
			wbyte(4'(i % 4 + 1), ALM_OFS_FLAG_MASK, mk);
			wbyte(4'(i % 4 + 1), ALM_OFS_FLAG_VAL, fv);
			fl = (i % 3 == 0) ? ((fv & mk) | (8'($urandom) & ~mk)) : 8'($urandom);
			sp = (i % 5 == 0) ? 16'hFFFF : ((i % 5 == 1) ? {8'h00, mn} : 16'($urandom));
			seg_flags_i <= fl;
			seg_port_i <= sp;
			seg_protocol_i <= (i % 7 == 3) ? ~pr : pr;
			seg_src_port_i <= 4'(i % 4 + 1);
			fok = !fen || ((fl & mk) == (fv & mk));
			pok = (m == ALM_CMP_OFF) || (m == ALM_CMP_EQ && (sp == {8'h00, mn} || sp == 16'hFFFF)) ||
				(m == ALM_CMP_IN && sp >= {8'h00, mn}) || (m == ALM_CMP_OUT && sp < {8'h00, mn});
			rd(ALM_ADR_MATCH, {30'h0, fok && pok && (i % 7 != 3), fok}, "match status");
			chk("flag_hit_o", {31'h0, flag_hit_o}, {31'h0, fok});
			chk("l4_hit_o", {31'h0, l4_hit_o}, {31'h0, fok && pok && (i % 7 != 3)});
		end
		seg_src_port_i <= 4'h0;
		rd(ALM_ADR_MATCH, 32'h0, "no source port");
		chk("flag_hit_o", {31'h0, flag_hit_o}, 32'h0);
		// reset in mid-run must clear every rule byte again
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk("outputs in reset", {28'h0, ack_o, flag_hit_o, l4_hit_o, |dat_o}, 32'h0);
		rst_i <= 1'b0;
		for (int p = 1; p <= 4; p++) begin
			for (int o = 5; o <= 10; o++) begin
				img[p][o] = ALM_RST_BYTE;
				rbyte(p[3:0], o[7:0]);
			end
		end
		repeat (3) @(posedge clk_i);
		chk("pending reads", exp_q.size(), 32'h0);
		summarize();
	end
endmodule : alm_store_test
